// ### logic/rtsc_map.svh
`ifndef RTSC_MAP_SVH
`define RTSC_MAP_SVH

// Strap sampling delay after reset release, in nanoseconds
`define RTSC_STRAP_DELAY_NS   1500
// Clock period in nanoseconds (10 MHz)
`define RTSC_CLK_PERIOD_NS    100
// Cycles from release to strap sample, rounded down
`define RTSC_STRAP_CYCLES     (`RTSC_STRAP_DELAY_NS / `RTSC_CLK_PERIOD_NS)
// Last counter value in the wait phase; the sample phase adds one cycle
`define RTSC_WAIT_LAST        (`RTSC_STRAP_CYCLES - 2)
// Counter width
`define RTSC_CNT_W            5
// Number of strap pins and gpio bits
`define RTSC_STRAPS           8
`define RTSC_GPIO_W           20
`define RTSC_TEST_MODE_SELECT_W          3
// Position of the second output trigger among the strap pins
`define RTSC_TRIG_B_POS       4
// Reset values
`define RTSC_ZERO8            8'h00
`define RTSC_ZERO20           20'h00000
`define RTSC_ZERO3            3'h0
`define RTSC_ZERO5            5'h00
`define RTSC_ZERO4            4'h0
// Flash pins in reset: values 0, chip selects idle high, no enables
`define RTSC_CS_IDLE          4'hA

`endif

// ### logic/rtsc_pkg.sv
package rtsc_pkg;

	// Sequencer states
	typedef enum logic [1:0] {
		RTSC_HOLD   = 2'b00,
		RTSC_WAIT   = 2'b01,
		RTSC_SAMPLE = 2'b10,
		RTSC_RUN    = 2'b11
	} rtsc_state_e;

	// Strap and enable bundle width types
	typedef logic [7:0]  rtsc_strap_t;
	typedef logic [19:0] rtsc_gpio_t;
	typedef logic [2:0]  rtsc_test_mode_select_t;

endpackage

// ### logic/rtsc_sync_if.sv
`timescale 1ns/100ps
// Synchronised pin levels passed from the input stage to the sequencer
interface rtsc_sync_if;
	logic                 por_n;      // Synchronised reset pin
	logic                 park_n;     // Synchronised park pin
	rtsc_pkg::rtsc_strap_t straps;    // Synchronised strap pins

	modport src (output por_n, output park_n, output straps);
	modport dst (input por_n, input park_n, input straps);
endinterface

// ### logic/rtsc_sync.sv
`timescale 1ns/100ps
`include "rtsc_map.svh"
// Two-flop synchroniser for all asynchronous pin inputs
module rtsc_sync (
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	input  wire logic                  por_in_n_i,
	input  wire logic                  mirror_park_in_n_i,
	input  wire rtsc_pkg::rtsc_strap_t strap_pin_i,
	rtsc_sync_if.src                   sync
);
	// First and second stage flops
	logic [`RTSC_STRAPS+1:0] meta_reg;
	logic [`RTSC_STRAPS+1:0] meta_next;
	logic [`RTSC_STRAPS+1:0] stab_reg;
	logic [`RTSC_STRAPS+1:0] stab_next;

	// Next values: sample pins, then move first stage to second
	always_comb begin
		meta_next = {por_in_n_i, mirror_park_in_n_i, strap_pin_i};
		stab_next = meta_reg;
	end

	// Register both stages; reset reads pins as held in reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_reg <= '0;
			stab_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			stab_reg <= stab_next;
		end
	end

	// Only the second stage leaves this module
	assign sync.por_n  = stab_reg[`RTSC_STRAPS+1];
	assign sync.park_n = stab_reg[`RTSC_STRAPS];
	assign sync.straps = stab_reg[`RTSC_STRAPS-1:0];
endmodule

// ### logic/rtsc_top.sv
`timescale 1ns/100ps
`include "rtsc_map.svh"
// Summary of operation
// - Reset pin rising edge starts self-configuration
// - Flash port and gpio tri-stated in reset
// - Illumination selects and mirror enable driven low
// - No output active while reset held
// - Straps floated, sampled 1.5 us later, driven
// - Strap pins 0..2 form test mode select
// - Strap pin 4 carries second output trigger
module rtsc_top (
	input  wire logic                  clk_i,               // 10 MHz system clock
	input  wire logic                  reset_i,             // Synchronous internal reset
	input  wire logic                  por_in_n_i,          // Power-on reset pin
	input  wire logic                  mirror_park_in_n_i,  // Park pin
	input  wire rtsc_pkg::rtsc_strap_t strap_pin_i,         // Strap pin input levels
	input  wire logic                  fn_flash_sclk_i,     // Functional flash clock
	input  wire logic                  fn_flash_sdo_i,      // Functional flash data
	input  wire logic                  fn_flash_sel0_n_i,   // Functional chip select 0
	input  wire logic                  fn_flash_sel1_n_i,   // Functional chip select 1
	input  wire rtsc_pkg::rtsc_gpio_t  fn_gpio_out_i,       // Functional gpio levels
	input  wire rtsc_pkg::rtsc_gpio_t  fn_gpio_oe_i,        // Functional gpio enables
	input  wire logic                  fn_illum_select0_i,  // Functional illum select 0
	input  wire logic                  fn_illum_select1_i,  // Functional illum select 1
	input  wire logic                  fn_mirror_en_n_i,    // Functional mirror enable
	input  wire logic                  fn_out_trigger_b_i,  // Functional second trigger
	input  wire rtsc_pkg::rtsc_strap_t fn_strap_out_i,      // Functional test outputs
	output logic                       flash_port_sclk_o,
	output logic                       flash_port_sclk_oe_o,
	output logic                       flash_port_sdo_o,
	output logic                       flash_port_sdo_oe_o,
	output logic                       flash_port_sel0_n_o,
	output logic                       flash_port_sel0_n_oe_o,
	output logic                       flash_port_sel1_n_o,
	output logic                       flash_port_sel1_n_oe_o,
	output rtsc_pkg::rtsc_gpio_t       gpio_o,
	output rtsc_pkg::rtsc_gpio_t       gpio_oe_o,
	output logic                       illum_select0_o,
	output logic                       illum_select1_o,
	output logic                       mirror_array_enable_n_o,
	output rtsc_pkg::rtsc_strap_t      strap_pin_o,
	output rtsc_pkg::rtsc_strap_t      strap_pin_oe_o,
	output rtsc_pkg::rtsc_test_mode_select_t      test_mode_select_o,  // Captured strap value
	output logic                       config_start_o,      // One-cycle start pulse
	output logic                       released_o,          // Device out of reset
	output logic                       park_released_o      // Both pins seen high
);
	// Synchronised pins
	rtsc_sync_if sync ();

	// Input synchroniser instance
	rtsc_sync u_sync (
		.clk_i              (clk_i),
		.reset_i            (reset_i),
		.por_in_n_i         (por_in_n_i),
		.mirror_park_in_n_i (mirror_park_in_n_i),
		.strap_pin_i        (strap_pin_i),
		.sync               (sync)
	);

	// Sequencer state
	rtsc_pkg::rtsc_state_e  state_reg,  state_next;  // Current phase
	logic                   por_d_reg,  por_d_next;  // Delayed reset level
	logic [`RTSC_CNT_W-1:0] cnt_reg,    cnt_next;    // Strap delay counter
	rtsc_pkg::rtsc_test_mode_select_t  test_mode_select_reg,  test_mode_select_next;  // Captured select
	logic                   start_reg,  start_next;  // Start pulse
	logic                   run_reg,    run_next;    // Outputs functional
	logic                   drv_reg,    drv_next;    // Straps driven
	logic                   park_reg,   park_next;   // Both pins high

	// Output stage
	logic                  fsclk_reg, fsclk_oe_reg, fsdo_reg, fsdo_oe_reg;
	logic                  fcs0_reg, fcs0_oe_reg, fcs1_reg, fcs1_oe_reg;
	rtsc_pkg::rtsc_gpio_t  gpio_reg, gpio_oe_reg;
	logic                  ill0_reg, ill1_reg, men_reg;
	rtsc_pkg::rtsc_strap_t strap_reg, strap_oe_reg;

	// Sequencer next values
	always_comb begin
		state_next = state_reg;
		por_d_next = sync.por_n;
		cnt_next   = cnt_reg;
		test_mode_select_next = test_mode_select_reg;
		start_next = 1'b0;
		run_next   = run_reg;
		drv_next   = drv_reg;
		park_next  = run_reg & sync.por_n & sync.park_n;
		if (!sync.por_n) begin
			// Reset pin low: return to hold from any phase
			state_next = rtsc_pkg::RTSC_HOLD;
			cnt_next   = `RTSC_ZERO5;
			test_mode_select_next = `RTSC_ZERO3;
			run_next   = 1'b0;
			drv_next   = 1'b0;
			park_next  = 1'b0;
		end else begin
			case (state_reg)
				rtsc_pkg::RTSC_HOLD: begin
					// Rising edge of reset pin
					if (!por_d_reg) begin
						state_next = rtsc_pkg::RTSC_WAIT;
						start_next = 1'b1;
						run_next   = 1'b1;
						cnt_next   = `RTSC_ZERO5;
					end
				end
				rtsc_pkg::RTSC_WAIT: begin
					// Count out the strap delay
					cnt_next = cnt_reg + `RTSC_CNT_W'(1);
					if (cnt_reg == `RTSC_CNT_W'(`RTSC_WAIT_LAST)) begin
						state_next = rtsc_pkg::RTSC_SAMPLE;
					end
				end
				rtsc_pkg::RTSC_SAMPLE: begin
					// Capture select bits, then drive straps
					test_mode_select_next = sync.straps[`RTSC_TEST_MODE_SELECT_W-1:0];
					drv_next   = 1'b1;
					state_next = rtsc_pkg::RTSC_RUN;
				end
				rtsc_pkg::RTSC_RUN: begin
					// Hold captured select until next reset
					state_next = rtsc_pkg::RTSC_RUN;
				end
				default: begin
					state_next = rtsc_pkg::RTSC_HOLD;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= rtsc_pkg::RTSC_HOLD;
			por_d_reg <= 1'b0;
			cnt_reg   <= `RTSC_ZERO5;
			test_mode_select_reg <= `RTSC_ZERO3;
			start_reg <= 1'b0;
			run_reg   <= 1'b0;
			drv_reg   <= 1'b0;
			park_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			por_d_reg <= por_d_next;
			cnt_reg   <= cnt_next;
			test_mode_select_reg <= test_mode_select_next;
			start_reg <= start_next;
			run_reg   <= run_next;
			drv_reg   <= drv_next;
			park_reg  <= park_next;
		end
	end

	// Output stage: gate functional values by phase
	logic                  o_sclk, o_sclk_oe, o_sdo, o_sdo_oe;
	logic                  o_cs0, o_cs0_oe, o_cs1, o_cs1_oe;
	rtsc_pkg::rtsc_gpio_t  o_gpio, o_gpio_oe;
	logic                  o_ill0, o_ill1, o_men;
	rtsc_pkg::rtsc_strap_t o_strap, o_strap_oe;

	always_comb begin
		// Flash port and gpio float while not running
		o_sclk     = run_next & fn_flash_sclk_i;
		o_sclk_oe  = run_next;
		o_sdo      = run_next & fn_flash_sdo_i;
		o_sdo_oe   = run_next;
		o_cs0      = run_next ? fn_flash_sel0_n_i : 1'b1;
		o_cs0_oe   = run_next;
		o_cs1      = run_next ? fn_flash_sel1_n_i : 1'b1;
		o_cs1_oe   = run_next;
		o_gpio     = run_next ? fn_gpio_out_i : `RTSC_ZERO20;
		o_gpio_oe  = run_next ? fn_gpio_oe_i : `RTSC_ZERO20;
		// Forced low outputs
		o_ill0     = run_next & fn_illum_select0_i;
		o_ill1     = run_next & fn_illum_select1_i;
		o_men      = run_next & fn_mirror_en_n_i;
		// Straps float until sampled, then driven
		o_strap    = drv_next ? fn_strap_out_i : `RTSC_ZERO8;
		o_strap[`RTSC_TRIG_B_POS] = drv_next & fn_out_trigger_b_i;
		o_strap_oe = drv_next ? {`RTSC_STRAPS{1'b1}} : `RTSC_ZERO8;
	end

	// Output registers, released values from reset
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			{fsclk_reg, fsclk_oe_reg, fsdo_reg, fsdo_oe_reg} <= `RTSC_ZERO4;
			{fcs0_reg, fcs0_oe_reg, fcs1_reg, fcs1_oe_reg}   <= `RTSC_CS_IDLE;
			gpio_reg     <= `RTSC_ZERO20;
			gpio_oe_reg  <= `RTSC_ZERO20;
			{ill0_reg, ill1_reg, men_reg} <= `RTSC_ZERO3;
			strap_reg    <= `RTSC_ZERO8;
			strap_oe_reg <= `RTSC_ZERO8;
		end else begin
			{fsclk_reg, fsclk_oe_reg, fsdo_reg, fsdo_oe_reg} <= {o_sclk, o_sclk_oe, o_sdo, o_sdo_oe};
			{fcs0_reg, fcs0_oe_reg, fcs1_reg, fcs1_oe_reg}   <= {o_cs0, o_cs0_oe, o_cs1, o_cs1_oe};
			gpio_reg     <= o_gpio;
			gpio_oe_reg  <= o_gpio_oe;
			{ill0_reg, ill1_reg, men_reg} <= {o_ill0, o_ill1, o_men};
			strap_reg    <= o_strap;
			strap_oe_reg <= o_strap_oe;
		end
	end

	// Port assignments straight from flops
	assign flash_port_sclk_o       = fsclk_reg;
	assign flash_port_sclk_oe_o    = fsclk_oe_reg;
	assign flash_port_sdo_o        = fsdo_reg;
	assign flash_port_sdo_oe_o     = fsdo_oe_reg;
	assign flash_port_sel0_n_o     = fcs0_reg;
	assign flash_port_sel0_n_oe_o  = fcs0_oe_reg;
	assign flash_port_sel1_n_o     = fcs1_reg;
	assign flash_port_sel1_n_oe_o  = fcs1_oe_reg;
	assign gpio_o                  = gpio_reg;
	assign gpio_oe_o               = gpio_oe_reg;
	assign illum_select0_o         = ill0_reg;
	assign illum_select1_o         = ill1_reg;
	assign mirror_array_enable_n_o = men_reg;
	assign strap_pin_o             = strap_reg;
	assign strap_pin_oe_o          = strap_oe_reg;
	assign test_mode_select_o      = test_mode_select_reg;
	assign config_start_o          = start_reg;
	assign released_o              = run_reg;
	assign park_released_o         = park_reg;
endmodule

// ### bench/rtsc_properties.sv
`timescale 1ns/100ps
// Port checker for the reset and strap sequencer
module rtsc_properties (
	input wire logic                  clk_i,
	input wire logic                  reset_i,
	input wire logic                  por_in_n_i,
	input wire logic                  fn_out_trigger_b_i,
	input wire logic                  flash_port_sclk_oe_o,
	input wire logic                  flash_port_sdo_oe_o,
	input wire rtsc_pkg::rtsc_gpio_t  gpio_oe_o,
	input wire logic                  illum_select0_o,
	input wire logic                  mirror_array_enable_n_o,
	input wire rtsc_pkg::rtsc_strap_t strap_pin_o,
	input wire rtsc_pkg::rtsc_strap_t strap_pin_oe_o,
	input wire rtsc_pkg::rtsc_test_mode_select_t test_mode_select_o,
	input wire logic                  config_start_o,
	input wire logic                  released_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	// Start of self-configuration
	sequence start_s;
		$rose(config_start_o);
	endsequence
	start_pulse_a: assert property (config_start_o |=> !config_start_o)
		else $error("start pulse too long");
	start_rel_a: assert property ($rose(released_o) |-> config_start_o)
		else $error("release without start");
	pins_float_a: assert property (!released_o |-> !flash_port_sclk_oe_o
		&& !flash_port_sdo_oe_o && gpio_oe_o == 20'h00000) else $error("pin driven in reset");
	pins_low_a: assert property (!released_o |-> !illum_select0_o
		&& !mirror_array_enable_n_o) else $error("select not low in reset");
	por_off_a: assert property ((!por_in_n_i) [*5] |-> !released_o)
		else $error("active while reset pin low");
	strap_float_a: assert property (start_s |-> (strap_pin_oe_o == 8'h00) [*8])
		else $error("strap driven too early");
	// Straps float through the wait, then all drive on the fifteenth edge
	strap_drive_a: assert property (start_s |-> ##14 (strap_pin_oe_o == 8'h00)
		##1 (strap_pin_oe_o == 8'hFF || !released_o)) else $error("strap not driven");
	test_mode_select_hold_a: assert property (released_o && strap_pin_oe_o[0] |=>
		$stable(test_mode_select_o) || !released_o) else $error("select changed");
	trig_out_a: assert property (strap_pin_oe_o[4] && $past(strap_pin_oe_o[4]) |->
		strap_pin_o[4] == $past(fn_out_trigger_b_i)) else $error("trigger mismatch");
endmodule

bind rtsc_top rtsc_properties chk (
	.clk_i                   (clk_i),
	.reset_i                 (reset_i),
	.por_in_n_i              (por_in_n_i),
	.fn_out_trigger_b_i      (fn_out_trigger_b_i),
	.flash_port_sclk_oe_o    (flash_port_sclk_oe_o),
	.flash_port_sdo_oe_o     (flash_port_sdo_oe_o),
	.gpio_oe_o               (gpio_oe_o),
	.illum_select0_o         (illum_select0_o),
	.mirror_array_enable_n_o (mirror_array_enable_n_o),
	.strap_pin_o             (strap_pin_o),
	.strap_pin_oe_o          (strap_pin_oe_o),
	.test_mode_select_o      (test_mode_select_o),
	.config_start_o          (config_start_o),
	.released_o              (released_o)
);

// ### bench/rtsc_board.sv
`timescale 1ns/100ps
// Board reset source and strap pulls
module rtsc_board (
	input  wire logic                  clk_i,
	input  wire logic                  por_cmd_i,
	input  wire rtsc_pkg::rtsc_strap_t pull_i,
	input  wire rtsc_pkg::rtsc_strap_t dev_i,
	input  wire rtsc_pkg::rtsc_strap_t dev_oe_i,
	output logic                       por_n_o,
	output logic                       park_n_o,
	output rtsc_pkg::rtsc_strap_t      strap_o
);
	int edges = 0; // Clock edges seen so far
	// Count edges to know the clock is running
	always @(posedge clk_i) edges <= edges + 1;
	assign por_n_o = por_cmd_i && edges > 2;
	// Host starts no serial traffic at all in these runs
	assign park_n_o = por_n_o;
	// Device drive wins, else pull-up, else weak pull-down
	assign strap_o = (dev_oe_i & dev_i) | (~dev_oe_i & pull_i);
endmodule

// ### bench/test_reset_and_test_strap_control.sv
`timescale 1ns/100ps
`include "rtsc_map.svh"
// Self-checking bench for the reset and strap sequencer
module test_reset_and_test_strap_control;
	localparam logic [19:0] START_LAT = 20'h00003; // Two sync flops plus start register
	logic clk_i, reset_i = 1'b1, por_cmd = 1'b0, por_in_n_i, mirror_park_in_n_i;
	logic fn_flash_sclk_i, fn_flash_sdo_i, fn_flash_sel0_n_i, fn_flash_sel1_n_i;
	logic fn_illum_select0_i, fn_illum_select1_i, fn_mirror_en_n_i, fn_out_trigger_b_i;
	logic flash_port_sclk_o, flash_port_sclk_oe_o, flash_port_sdo_o, flash_port_sdo_oe_o;
	logic flash_port_sel0_n_o, flash_port_sel0_n_oe_o, flash_port_sel1_n_o;
	logic flash_port_sel1_n_oe_o, illum_select0_o, illum_select1_o, mirror_array_enable_n_o;
	logic config_start_o, released_o, park_released_o;
	rtsc_pkg::rtsc_gpio_t  fn_gpio_out_i, fn_gpio_oe_i, gpio_o, gpio_oe_o;
	rtsc_pkg::rtsc_strap_t strap_pin_i, fn_strap_out_i, strap_pin_o, strap_pin_oe_o, pull;
	rtsc_pkg::rtsc_test_mode_select_t test_mode_select_o;
	logic [35:0]           fnv = 36'h000000000; // Random functional levels
	logic [31:0]           rng = 32'h00010ECB;  // Seed 69323
	logic [35:0]           snap;                // Levels taken by the next rising edge
	logic [2:0]            exp_sel;             // Select that must be held
	int                    fail_count = 0, n_tests = 0, cyc;
	assign {fn_flash_sclk_i, fn_flash_sdo_i, fn_flash_sel0_n_i, fn_flash_sel1_n_i,
		fn_illum_select0_i, fn_illum_select1_i, fn_mirror_en_n_i, fn_out_trigger_b_i,
		fn_strap_out_i, fn_gpio_out_i} = fnv;
	assign fn_gpio_oe_i = 20'hFFFFF;
	rtsc_top dut (
		.clk_i                   (clk_i),
		.reset_i                 (reset_i),
		.por_in_n_i              (por_in_n_i),
		.mirror_park_in_n_i      (mirror_park_in_n_i),
		.strap_pin_i             (strap_pin_i),
		.fn_flash_sclk_i         (fn_flash_sclk_i),
		.fn_flash_sdo_i          (fn_flash_sdo_i),
		.fn_flash_sel0_n_i       (fn_flash_sel0_n_i),
		.fn_flash_sel1_n_i       (fn_flash_sel1_n_i),
		.fn_gpio_out_i           (fn_gpio_out_i),
		.fn_gpio_oe_i            (fn_gpio_oe_i),
		.fn_illum_select0_i      (fn_illum_select0_i),
		.fn_illum_select1_i      (fn_illum_select1_i),
		.fn_mirror_en_n_i        (fn_mirror_en_n_i),
		.fn_out_trigger_b_i      (fn_out_trigger_b_i),
		.fn_strap_out_i          (fn_strap_out_i),
		.flash_port_sclk_o       (flash_port_sclk_o),
		.flash_port_sclk_oe_o    (flash_port_sclk_oe_o),
		.flash_port_sdo_o        (flash_port_sdo_o),
		.flash_port_sdo_oe_o     (flash_port_sdo_oe_o),
		.flash_port_sel0_n_o     (flash_port_sel0_n_o),
		.flash_port_sel0_n_oe_o  (flash_port_sel0_n_oe_o),
		.flash_port_sel1_n_o     (flash_port_sel1_n_o),
		.flash_port_sel1_n_oe_o  (flash_port_sel1_n_oe_o),
		.gpio_o                  (gpio_o),
		.gpio_oe_o               (gpio_oe_o),
		.illum_select0_o         (illum_select0_o),
		.illum_select1_o         (illum_select1_o),
		.mirror_array_enable_n_o (mirror_array_enable_n_o),
		.strap_pin_o             (strap_pin_o),
		.strap_pin_oe_o          (strap_pin_oe_o),
		.test_mode_select_o      (test_mode_select_o),
		.config_start_o          (config_start_o),
		.released_o              (released_o),
		.park_released_o         (park_released_o)
	);
	rtsc_board board (.clk_i(clk_i), .por_cmd_i(por_cmd), .pull_i(pull), .dev_i(strap_pin_o),
		.dev_oe_i(strap_pin_oe_o), .por_n_o(por_in_n_i), .park_n_o(mirror_park_in_n_i),
		.strap_o(strap_pin_i));
	// Xorshift source
	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	// New functional levels each falling edge
	always @(negedge clk_i) fnv <= {xs(), 4'(xs())};
	// Expected strap drive: functional levels with the trigger in its slot
	function automatic logic [7:0] exp_strap(logic [7:0] s, logic t);
		logic [7:0] r;
		r = s;
		r[`RTSC_TRIG_B_POS] = t;
		return r;
	endfunction
	// Clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// Value compare
	task automatic chk(string n, logic [19:0] e, logic [19:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// Everything quiet while the reset pin is low
	task automatic off_check();
		chk("gpio_oe", 20'h00000, gpio_oe_o);
		chk("flash_oe", 20'h00000, {16'h0000, flash_port_sclk_oe_o, flash_port_sdo_oe_o,
			flash_port_sel0_n_oe_o, flash_port_sel1_n_oe_o});
		chk("flash_val", 20'h00003, {16'h0000, flash_port_sclk_o, flash_port_sdo_o,
			flash_port_sel0_n_o, flash_port_sel1_n_o});
		chk("low_outs", 20'h00000, {17'h00000, illum_select0_o, illum_select1_o,
			mirror_array_enable_n_o});
		chk("active", 20'h00000, {9'h000, park_released_o, released_o, config_start_o,
			strap_pin_oe_o});
		chk("gpio_val", 20'h00000, gpio_o);
		chk("strap_val", 20'h00000, {12'h000, strap_pin_o});
		chk("test_mode_select_off", 20'h00000, {17'h00000, test_mode_select_o});
	endtask
	// Functional levels reach the pins one edge after they are applied
	task automatic run_check();
		chk("run_oe", 20'h03FFF, {6'h00, flash_port_sclk_oe_o, flash_port_sdo_oe_o,
			flash_port_sel0_n_oe_o, flash_port_sel1_n_oe_o, strap_pin_oe_o, released_o,
			park_released_o});
		chk("gpio_oe_run", 20'hFFFFF, gpio_oe_o);
		chk("gpio_run", snap[19:0], gpio_o);
		chk("flash_run", {16'h0000, snap[35:32]}, {16'h0000, flash_port_sclk_o,
			flash_port_sdo_o, flash_port_sel0_n_o, flash_port_sel1_n_o});
		chk("outs_run", {17'h00000, snap[31:29]}, {17'h00000, illum_select0_o,
			illum_select1_o, mirror_array_enable_n_o});
		chk("strap_run", {12'h000, exp_strap(snap[27:20], snap[28])},
			{12'h000, strap_pin_o});
	endtask
	// Verdict
	task automatic end_of_test();
		if (fail_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (3000) @(posedge clk_i);
		fail_count++;
		end_of_test();
	end
	// Main sequence
	initial begin
		pull = 8'h07;
		repeat (4) @(posedge clk_i);
		@(negedge clk_i) reset_i = 1'b0;
		repeat (6) @(negedge clk_i);
		off_check();
		for (int i = 0; i < 5; i++) begin
			// Straps: test select, normal low, then random levels
			pull = (i == 0) ? 8'h07 : (i == 1) ? 8'h00 : fn_strap_out_i;
			repeat (4) @(negedge clk_i);
			por_cmd = 1'b1;
			cyc = 0;
			while (config_start_o !== 1'b1 && cyc < 20) begin
				@(negedge clk_i);
				cyc++;
			end
			chk("start", 20'h00003, {18'h00000, config_start_o, released_o});
			chk("start_lat", START_LAT, cyc[19:0]);
			if (i == 2) begin
				// Pin dropped again before the straps are sampled
				repeat (6) @(negedge clk_i);
				por_cmd = 1'b0;
				repeat (6) @(negedge clk_i);
				off_check();
				continue;
			end
			cyc = 0;
			while (strap_pin_oe_o !== 8'hFF && cyc < 40) begin
				@(negedge clk_i);
				cyc++;
			end
			chk("strap_delay", 20'(`RTSC_STRAP_CYCLES), cyc[19:0]);
			chk("test_mode_select", {17'h00000, pull[2:0]}, {17'h00000, test_mode_select_o});
			exp_sel = pull[2:0];
			pull = 8'h00;
			#1;
			repeat (6) begin
				snap = fnv;
				@(negedge clk_i);
				#1;
				run_check();
			end
			chk("test_mode_select_hold", {17'h00000, exp_sel}, {17'h00000, test_mode_select_o});
			por_cmd = 1'b0;
			repeat (6) @(negedge clk_i);
			off_check();
		end
		end_of_test();
	end
endmodule
